// ===== src/smisrc_top.sv
/*
  Management interrupt source and clock command block: AXI4-Lite register
  slave, sticky status with write-one-to-clear, enables, event pin
  detection, clock command pulses and the active-low interrupt output.
  Assumes all inputs synchronous to clock_in; timers, wake logic and the
  clock switcher live outside and act on the pulses given here.
*/
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module smisrc_top (
  input  wire logic                                clock_in,
  input  wire logic                                arst_n_in,
  input  wire logic                                ce_in,
  input  wire smisrc_pkg::smisrc_axi_req_type      axi_req_in,
  output      smisrc_pkg::smisrc_axi_rsp_type      axi_rsp_out,
  input  wire smisrc_pkg::smisrc_primary_src_type  primary_src_in,
  input  wire smisrc_pkg::smisrc_secondary_src_type secondary_src_in,
  output      smisrc_pkg::smisrc_clock_cmd_type    clock_cmd_out,
  output      logic                                clock_full_speed_out,
  output      logic                                smi_n_out
);
  import smisrc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                  aw_full;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic                  w_full;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  logic                  bvalid;
  logic [1:0]            bresp;
  logic                  rvalid;
  logic [DATA_WIDTH-1:0] rdata;
  logic [1:0]            rresp;

  logic [3:0]            event_cfg;
  logic [5:0]            status_pri;
  logic [3:0]            status_sec;
  logic [7:0]            enable_pri;
  logic [3:0]            enable_sec;
  logic                  full_speed;
  logic [PIN_COUNT-1:0]  pin_prev;
  logic                  smi_n;
  smisrc_clock_cmd_type  clock_cmd;

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  logic                  aw_take;
  logic                  w_take;
  logic                  do_write;
  logic                  ar_take;
  logic [7:0]            wr_index;
  logic [7:0]            rd_index;
  logic                  wr_hit;
  logic                  rd_hit;
  logic                  wr_upper_ok;
  logic                  rd_upper_ok;

  assign aw_take  = ce_in && axi_req_in.awvalid && !aw_full;
  assign w_take   = ce_in && axi_req_in.wvalid && !w_full;
  // the write lands one edge after both halves are held
  assign do_write = ce_in && aw_full && w_full && !bvalid;
  assign ar_take  = ce_in && axi_req_in.arvalid && !rvalid;

  assign wr_index    = aw_addr[9:2];
  assign rd_index    = axi_req_in.araddr[9:2];
  assign wr_upper_ok = (aw_addr[ADDR_WIDTH-1:10] == '0);
  assign rd_upper_ok = (axi_req_in.araddr[ADDR_WIDTH-1:10] == '0);

  always_comb begin
    axi_rsp_out         = '0;
    axi_rsp_out.awready = !aw_full;
    axi_rsp_out.wready  = !w_full;
    axi_rsp_out.bvalid  = bvalid;
    axi_rsp_out.bresp   = bresp;
    axi_rsp_out.arready = !rvalid;
    axi_rsp_out.rvalid  = rvalid;
    axi_rsp_out.rdata   = rdata;
    axi_rsp_out.rresp   = rresp;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_full <= 1'b1;
      aw_addr <= axi_req_in.awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w_full  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_full  <= 1'b1;
      w_byte  <= axi_req_in.wdata[7:0];
      w_lane0 <= axi_req_in.wstrb[0];
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  // write decode: only lane 0 carries register data
  logic wr_cmd;
  logic wr_cfg;
  logic wr_st0;
  logic wr_st1;
  logic wr_en0;
  logic wr_en1;

  always_comb begin
    wr_cmd = 1'b0;
    wr_cfg = 1'b0;
    wr_st0 = 1'b0;
    wr_st1 = 1'b0;
    wr_en0 = 1'b0;
    wr_en1 = 1'b0;
    wr_hit = 1'b1;
    if (!wr_upper_ok) begin
      wr_hit = 1'b0;
    end else if (wr_index == IDX_COMMAND) begin
      wr_cmd = do_write && w_lane0;
    end else if (wr_index == IDX_EVENT_CFG) begin
      wr_cfg = do_write && w_lane0;
    end else if (wr_index == IDX_STATUS_PRI) begin
      wr_st0 = do_write && w_lane0;
    end else if (wr_index == IDX_STATUS_SEC) begin
      wr_st1 = do_write && w_lane0;
    end else if (wr_index == IDX_ENABLE_PRI) begin
      wr_en0 = do_write && w_lane0;
    end else if (wr_index == IDX_ENABLE_SEC) begin
      wr_en1 = do_write && w_lane0;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce_in) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req_in.bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (!rd_upper_ok) begin
      rd_hit = 1'b0;
    end else if (rd_index == IDX_COMMAND) begin
      rd_byte = {7'h00, full_speed};
    end else if (rd_index == IDX_EVENT_CFG) begin
      rd_byte = {4'h0, event_cfg};
    end else if (rd_index == IDX_STATUS_PRI) begin
      rd_byte = {(|status_sec), 1'b0, status_pri};
    end else if (rd_index == IDX_STATUS_SEC) begin
      rd_byte = {4'h0, status_sec};
    end else if (rd_index == IDX_ENABLE_PRI) begin
      rd_byte = {enable_pri[GLOBAL_EN_BIT], 1'b0, enable_pri[5:0]};
    end else if (rd_index == IDX_ENABLE_SEC) begin
      rd_byte = {4'h0, enable_sec};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (ce_in) begin
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rd_byte};
        rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req_in.rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration and enables
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      event_cfg <= RST_EVENT_CFG;
    end else if (ce_in && wr_cfg) begin
      event_cfg <= w_byte[3:0];
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      enable_pri <= RST_ENABLE_PRI;
      enable_sec <= RST_ENABLE_SEC;
    end else if (ce_in) begin
      if (wr_en0) begin
        enable_pri <= {w_byte[7], 1'b0, w_byte[5:0]};
      end
      if (wr_en1) begin
        enable_sec <= w_byte[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // command port: acts only, stores nothing but the speed state
  // ----------------------------------------------------------------
  logic cmd_slow;
  logic cmd_fast;
  logic cmd_stop;
  logic cmd_soft;

  assign cmd_slow = wr_cmd && w_byte[CMD_SLOW_BIT];
  assign cmd_fast = wr_cmd && w_byte[CMD_FAST_BIT];
  assign cmd_stop = wr_cmd && w_byte[CMD_STOP_BIT];
  assign cmd_soft = wr_cmd && w_byte[CMD_SOFT_BIT];

  // one-cycle pulses to the external clock switcher, which applies
  // whichever slowing or stopping method it is configured for
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clock_cmd <= '0;
    end else if (ce_in) begin
      clock_cmd.slow_down_cmd  <= cmd_slow && !cmd_fast;
      clock_cmd.full_speed_cmd <= cmd_fast;
      clock_cmd.stop_clock_cmd <= cmd_stop;
    end
  end

  // fast wins when software breaks the rule and sets both
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      full_speed <= RST_FULL_SPEED;
    end else if (ce_in) begin
      if (cmd_fast) begin
        full_speed <= 1'b1;
      end else if (cmd_slow) begin
        full_speed <= 1'b0;
      end
    end
  end

  assign clock_cmd_out        = clock_cmd;
  assign clock_full_speed_out = full_speed;

  // ----------------------------------------------------------------
  // event pin detection
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pin_hit;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_prev <= '0;
    end else if (ce_in) begin
      pin_prev <= secondary_src_in.event_pins;
    end
  end

  // pin_prev resets low, but event_cfg resets to low-level detection, so a
  // pin already high after reset sets no status bit
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    smisrc_detect_type mode;
    logic              now;
    logic              was;
    assign mode = smisrc_detect_type'(event_cfg[p*PIN_CFG_WIDTH +: PIN_CFG_WIDTH]);
    assign now  = secondary_src_in.event_pins[p];
    assign was  = pin_prev[p];
    always_comb begin
      case (mode)
        DET_LOW_LEVEL:  pin_hit[p] = !now;
        DET_HIGH_LEVEL: pin_hit[p] = now;
        DET_FALL_EDGE:  pin_hit[p] = was && !now;
        default:        pin_hit[p] = !was && now;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky status: a source in the clearing cycle keeps its bit
  // ----------------------------------------------------------------
  logic [5:0] next_status_pri;
  logic [3:0] next_status_sec;
  logic [5:0] clr_pri;
  logic [3:0] clr_sec;
  logic [3:0] set_sec;

  assign clr_pri = wr_st0 ? w_byte[5:0] : 6'h00;
  assign clr_sec = wr_st1 ? w_byte[3:0] : 4'h0;
  assign set_sec = {pin_hit, secondary_src_in.cpu_restart_request, cmd_soft};

  assign next_status_pri = (status_pri & ~clr_pri) | primary_src_in;
  assign next_status_sec = (status_sec & ~clr_sec) | set_sec;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_pri <= RST_STATUS_PRI;
      status_sec <= RST_STATUS_SEC;
    end else if (ce_in) begin
      status_pri <= next_status_pri;
      status_sec <= next_status_sec;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  logic pending;

  // the handler must drop and restore the global enable to get a fresh
  // falling edge while a source stays active
  assign pending = enable_pri[GLOBAL_EN_BIT]
                && ((|(status_pri & enable_pri[5:0]))
                 || (|(status_sec & enable_sec)));

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      smi_n <= 1'b1;
    end else if (ce_in) begin
      smi_n <= !pending;
    end
  end

  assign smi_n_out = smi_n;

endmodule : smisrc_top

// ===== src/smisrc_pkg.sv
/*
  Shared constants and types for the management interrupt source and
  clock command block: register indices, field positions, reset values,
  bus and event carriers.
  Assumes a 32-bit AXI4-Lite master and a 12-bit byte address.
*/
// Contract
// - command write acts on each bit set; bit 0 is ignored when bit 1 is also set
// - command port keeps no written value
// - command bit 0 slows the clock
// - command bit 1 restores full speed
// - command bit 2 stops the clock
// - command bit 3 raises software event
// - command read returns clock speed bit 0
// - config 1:0 selects first pin detection
// - config 3:2 selects second pin detection
// - primary status bits show active sources
// - primary status write-one clears, except bit 7
// - primary bit 7 is OR of secondary
// - secondary status shows sources, write-one clears
// - enable bits allow or block sources
// - primary enable bit 7 is global enable
package smisrc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_COMMAND    = 8'h8e;
  localparam logic [7:0] IDX_EVENT_CFG  = 8'h8f;
  localparam logic [7:0] IDX_STATUS_PRI = 8'h90;
  localparam logic [7:0] IDX_STATUS_SEC = 8'h91;
  localparam logic [7:0] IDX_ENABLE_PRI = 8'h92;
  localparam logic [7:0] IDX_ENABLE_SEC = 8'h93;

  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_SLOW_BIT    = 0;
  localparam int CMD_FAST_BIT    = 1;
  localparam int CMD_STOP_BIT    = 2;
  localparam int CMD_SOFT_BIT    = 3;
  localparam int STAT_SEC_OR_BIT = 7;
  localparam int GLOBAL_EN_BIT   = 7;
  localparam int SEC_SOFT_BIT    = 0;
  localparam int SEC_RESTART_BIT = 1;
  localparam int SEC_PIN0_BIT    = 2;
  localparam int PRI_SRC_COUNT   = 6;
  localparam int SEC_SRC_COUNT   = 4;
  localparam int PIN_COUNT       = 2;
  localparam int PIN_CFG_WIDTH   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_EVENT_CFG  = 4'h0;
  localparam logic [5:0] RST_STATUS_PRI = 6'h00;
  localparam logic [3:0] RST_STATUS_SEC = 4'h0;
  localparam logic [7:0] RST_ENABLE_PRI = 8'h00;
  localparam logic [3:0] RST_ENABLE_SEC = 4'h0;
  localparam logic       RST_FULL_SPEED = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pin detection modes
  typedef enum logic [1:0] {
    DET_LOW_LEVEL  = 2'h0,
    DET_HIGH_LEVEL = 2'h1,
    DET_FALL_EDGE  = 2'h2,
    DET_RISE_EDGE  = 2'h3
  } smisrc_detect_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  awvalid;
    logic [ADDR_WIDTH-1:0] awaddr;
    logic [2:0]            awprot;
    logic                  wvalid;
    logic [DATA_WIDTH-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [ADDR_WIDTH-1:0] araddr;
    logic [2:0]            arprot;
    logic                  rready;
  } smisrc_axi_req_type;

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [DATA_WIDTH-1:0] rdata;
    logic [1:0]            rresp;
  } smisrc_axi_rsp_type;

  // source order matches the primary status bits 5:0
  typedef struct packed {
    logic halt_cycle;
    logic io_restart;
    logic second_wake_source;
    logic first_wake_source;
    logic second_idle_timer;
    logic first_idle_timer;
  } smisrc_primary_src_type;

  typedef struct packed {
    logic                 cpu_restart_request;
    logic [PIN_COUNT-1:0] event_pins;
  } smisrc_secondary_src_type;

  typedef struct packed {
    logic slow_down_cmd;
    logic full_speed_cmd;
    logic stop_clock_cmd;
  } smisrc_clock_cmd_type;

endpackage : smisrc_pkg

// ===== test/smisrc_assertions.sv
/*
  Port-level checker for smisrc_top.
  Assumes AW and W are offered together and ce_in is high around every
  bus transfer.
*/
`timescale 1ns/100ps
module smisrc_assertions (
  input wire logic                           clock_in,
  input wire logic                           arst_n_in,
  input wire logic                           ce_in,
  input wire smisrc_pkg::smisrc_axi_req_type axi_req_in,
  input wire smisrc_pkg::smisrc_axi_rsp_type axi_rsp_out,
  input wire smisrc_pkg::smisrc_primary_src_type primary_src_in,
  input wire smisrc_pkg::smisrc_clock_cmd_type clock_cmd_out,
  input wire logic                           clock_full_speed_out,
  input wire logic                           smi_n_out
);
  import smisrc_pkg::*;
  // ------------------------------------------------------------
  // transfer decode and enable shadow
  // ------------------------------------------------------------
  wire       wt = axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid
                  && axi_rsp_out.wready && ce_in && axi_req_in.wstrb[0]
                  && axi_req_in.awaddr[11:10] == 2'h0;
  wire       wc = wt && axi_req_in.awaddr[9:2] == IDX_COMMAND;
  wire       rt = axi_req_in.arvalid && axi_rsp_out.arready && ce_in
                  && axi_req_in.araddr[11:10] == 2'h0;
  wire [7:0] wd = axi_req_in.wdata[7:0];
  logic [7:0] en_q;
  // shadow runs one edge ahead of the design's own enable register
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_q <= 8'h00;
    end else if (wt && axi_req_in.awaddr[9:2] == IDX_ENABLE_PRI) begin
      en_q <= wd;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_slow;
    wc && wd[0] && !wd[1] |-> ##2 (clock_cmd_out.slow_down_cmd && !clock_full_speed_out);
  endproperty
  a_slow: assert property (p_slow) else $error("slow command not seen");
  property p_fast;
    wc && wd[1] |-> ##2 (clock_cmd_out.full_speed_cmd && clock_full_speed_out);
  endproperty
  a_fast: assert property (p_fast) else $error("full speed command not seen");
  property p_stop;
    wc && wd[2] |-> ##2 clock_cmd_out.stop_clock_cmd;
  endproperty
  a_stop: assert property (p_stop) else $error("stop command not seen");
  property p_idle;
    wc && wd[2:0] == 3'h0 |-> ##2 clock_cmd_out == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("command pulse without bit");
  property p_pulse;
    clock_cmd_out != 3'h0 |=> clock_cmd_out == 3'h0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command pulse too long");
  property p_speed;
    rt && axi_req_in.araddr[9:2] == IDX_COMMAND
      |=> axi_rsp_out.rvalid && axi_rsp_out.rdata == {31'h0, $past(clock_full_speed_out)};
  endproperty
  a_speed: assert property (p_speed) else $error("speed read wrong");
  property p_glob;
    (!en_q[7]) [*3] |-> smi_n_out;
  endproperty
  a_glob: assert property (p_glob) else $error("interrupt with global off");
  property p_smi;
    |(6'(primary_src_in) & en_q[5:0]) && en_q[7] ##1 en_q[7] |=> !smi_n_out;
  endproperty
  a_smi: assert property (p_smi) else $error("enabled source gave no interrupt");
  property p_src;
    rt && axi_req_in.araddr[9:2] == IDX_STATUS_PRI
      |=> (axi_rsp_out.rdata[5:0] & 6'($past(primary_src_in, 2))) == 6'($past(primary_src_in, 2));
  endproperty
  a_src: assert property (p_src) else $error("source missing in status");
  c_soft: cover property (wc && wd[3]);
  c_smi: cover property ($fell(smi_n_out));
  c_err: cover property (axi_rsp_out.bvalid && axi_rsp_out.bresp == RESP_SLVERR);
endmodule : smisrc_assertions

bind smisrc_top smisrc_assertions u_chk (
  .clock_in             (clock_in),
  .arst_n_in            (arst_n_in),
  .ce_in                (ce_in),
  .axi_req_in           (axi_req_in),
  .axi_rsp_out          (axi_rsp_out),
  .primary_src_in       (primary_src_in),
  .clock_cmd_out        (clock_cmd_out),
  .clock_full_speed_out (clock_full_speed_out),
  .smi_n_out            (smi_n_out)
);

// ===== test/smisrc_cpu_model.sv
/*
  CPU-side partner: counts clock command pulses and interrupt falls,
  raises a restart request one cycle after it is cued.
  Assumes the same clock and reset as the block.
*/
`timescale 1ns/100ps
module smisrc_cpu_model (
  input  wire logic                             clock_in,
  input  wire logic                             arst_n_in,
  input  wire smisrc_pkg::smisrc_clock_cmd_type cmd_in,
  input  wire logic                             smi_n_in,
  input  wire logic                             go_in,
  output      logic                             req_out,
  output      logic [7:0]                       slow_out,
  output      logic [7:0]                       fast_out,
  output      logic [7:0]                       stop_out,
  output      logic [7:0]                       fall_out
);
  import smisrc_pkg::*;
  logic smi_prev;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_out <= 1'b0;
    end else begin
      req_out <= go_in;
    end
  end
  // only a fresh falling edge counts, as an edge-sensitive cpu sees it
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {slow_out, fast_out, stop_out, fall_out} <= 32'h0;
      smi_prev <= 1'b1;
    end else begin
      slow_out <= slow_out + 8'(cmd_in.slow_down_cmd);
      fast_out <= fast_out + 8'(cmd_in.full_speed_cmd);
      stop_out <= stop_out + 8'(cmd_in.stop_clock_cmd);
      fall_out <= fall_out + 8'(smi_prev && !smi_n_in);
      smi_prev <= smi_n_in;
    end
  end
endmodule : smisrc_cpu_model

// ===== test/tb_smisrc_top.sv
/*
  Bench for smisrc_top: AXI4-Lite register tasks and directed sequences.
  Drops ce_in for one cycle to show that state freezes; the CPU model sits
  on the far side.
*/
`timescale 1ns/100ps
module tb_smisrc_top;
  import smisrc_pkg::*;
  localparam logic [7:0] CMD_SEQ [6] = '{8'h01, 8'h00, 8'h02, 8'h04, 8'h01, 8'h02};
  localparam logic [5:0] SPEED   = 6'h2c;
  logic                     clock_in;
  logic                     arst_n_in;
  smisrc_axi_req_type       req;
  smisrc_axi_rsp_type       rsp;
  smisrc_primary_src_type   psrc;
  smisrc_clock_cmd_type     cmd;
  logic                     fs;
  logic                     smi_n;
  logic                     go;
  logic                     ce;
  logic                     rreq;
  logic [1:0]               pins;
  logic [7:0]               n_slow, n_fast, n_stop, n_fall;
  int                       n_errors;
  int                       checks;
  smisrc_top u_dut (
    .clock_in             (clock_in),
    .arst_n_in            (arst_n_in),
    .ce_in                (ce),
    .axi_req_in           (req),
    .axi_rsp_out          (rsp),
    .primary_src_in       (psrc),
    .secondary_src_in     ({rreq, pins}),
    .clock_cmd_out        (cmd),
    .clock_full_speed_out (fs),
    .smi_n_out            (smi_n)
  );
  smisrc_cpu_model u_cpu (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .cmd_in    (cmd),
    .smi_n_in  (smi_n),
    .go_in     (go),
    .req_out   (rreq),
    .slow_out  (n_slow),
    .fast_out  (n_fast),
    .stop_out  (n_stop),
    .fall_out  (n_fall)
  );
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    logic dn;
    @(posedge clock_in);
    req.awaddr  <= {2'h0, i, 2'h0};
    req.wdata   <= {24'h0, d};
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    dn = 1'b0;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge clock_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        chk($sformatf("bresp %h", i), {30'h0, er}, {30'h0, rsp.bresp});
        req.bready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) chk("write handshake", 32'h1, 32'h0);
    if (!dn) results();
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
    logic dn;
    @(posedge clock_in);
    req.araddr  <= {2'h0, i, 2'h0};
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    dn = 1'b0;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge clock_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        chk($sformatf("reg %h", i), {24'h0, e}, rsp.rdata);
        chk($sformatf("rresp %h", i), {30'h0, er}, {30'h0, rsp.rresp});
        req.rready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) chk("read handshake", 32'h1, 32'h0);
    if (!dn) results();
  endtask : rd
  // interrupt output settles one edge after the register it follows
  task automatic sm(input logic e);
    repeat (2) @(posedge clock_in);
    chk("smi_n", {31'h0, e}, {31'h0, smi_n});
  endtask : sm
  // ------------------------------------------------------------
  // clock and sequence
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    arst_n_in = 1'b0;
    req = '0;
    psrc = '0;
    pins = 2'h3;
    go = 1'b0;
    ce = 1'b1;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge clock_in);
    arst_n_in <= 1'b1;
    rd(IDX_COMMAND, 8'h01, RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      wr(IDX_COMMAND, CMD_SEQ[k], RESP_OKAY);
      rd(IDX_COMMAND, {7'h0, SPEED[k]}, RESP_OKAY);
    end
    chk("slow pulses", 32'h2, {24'h0, n_slow});
    chk("fast pulses", 32'h2, {24'h0, n_fast});
    chk("stop pulses", 32'h1, {24'h0, n_stop});
    chk("speed pin", 32'h1, {31'h0, fs});
    wr(IDX_COMMAND, 8'h08, RESP_OKAY);
    rd(IDX_STATUS_SEC, 8'h01, RESP_OKAY);
    rd(IDX_STATUS_PRI, 8'h80, RESP_OKAY);
    sm(1'b1);
    wr(IDX_ENABLE_SEC, 8'h01, RESP_OKAY);
    sm(1'b1);
    wr(IDX_ENABLE_PRI, 8'h80, RESP_OKAY);
    sm(1'b0);
    wr(IDX_ENABLE_PRI, 8'h00, RESP_OKAY);
    sm(1'b1);
    wr(IDX_ENABLE_PRI, 8'h80, RESP_OKAY);
    sm(1'b0);
    chk("interrupt falls", 32'h2, {24'h0, n_fall});
    wr(IDX_STATUS_PRI, 8'h80, RESP_OKAY);
    rd(IDX_STATUS_PRI, 8'h80, RESP_OKAY);
    wr(IDX_STATUS_SEC, 8'h01, RESP_OKAY);
    rd(IDX_STATUS_PRI, 8'h00, RESP_OKAY);
    sm(1'b1);
    wr(IDX_ENABLE_PRI, 8'ha0, RESP_OKAY);
    psrc <= 6'h21;
    @(posedge clock_in);
    psrc <= 6'h00;
    rd(IDX_STATUS_PRI, 8'h21, RESP_OKAY);
    sm(1'b0);
    wr(IDX_STATUS_PRI, 8'h20, RESP_OKAY);
    rd(IDX_STATUS_PRI, 8'h01, RESP_OKAY);
    sm(1'b1);
    wr(IDX_STATUS_PRI, 8'h01, RESP_OKAY);
    // a source seen while ce_in is low must leave no mark
    ce <= 1'b0;
    psrc <= 6'h01;
    @(posedge clock_in);
    ce <= 1'b1;
    psrc <= 6'h00;
    rd(IDX_STATUS_PRI, 8'h00, RESP_OKAY);
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
    rd(IDX_STATUS_SEC, 8'h02, RESP_OKAY);
    wr(IDX_STATUS_SEC, 8'h02, RESP_OKAY);
    rd(IDX_STATUS_SEC, 8'h00, RESP_OKAY);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        pins[p] <= ~m[0];
        wr(IDX_EVENT_CFG, 8'(m << (2 * p)), RESP_OKAY);
        wr(IDX_STATUS_SEC, 8'h0c, RESP_OKAY);
        rd(IDX_STATUS_SEC, 8'h00, RESP_OKAY);
        pins[p] <= m[0];
        repeat (3) @(posedge clock_in);
        rd(IDX_STATUS_SEC, 8'h04 << p, RESP_OKAY);
        wr(IDX_STATUS_SEC, 8'h0c, RESP_OKAY);
        rd(IDX_STATUS_SEC, m[1] ? 8'h00 : 8'h04 << p, RESP_OKAY);
      end
    end
    wr(IDX_EVENT_CFG, 8'hff, RESP_OKAY);
    rd(IDX_EVENT_CFG, 8'h0f, RESP_OKAY);
    wr(8'h94, 8'h00, RESP_SLVERR);
    rd(8'h94, 8'h00, RESP_SLVERR);
    results();
  end
endmodule : tb_smisrc_top
